// *** hw/tues_pkg.sv ***
// Constants and carrier types for the tape unit ending-status block
package tues_pkg;

  // ==========================================================
  // Mux selector codes
  localparam logic [2:0] SEL_DEAD_TRACK = 3'h0;
  localparam logic [2:0] SEL_RW_ERRORS  = 3'h1;
  localparam logic [2:0] SEL_DIAG_AID   = 3'h2;
  localparam logic [2:0] SEL_STATUS     = 3'h3;

  // ==========================================================
  // Reject codes (octal in the comments)
  localparam logic [5:0] RJ_NONE      = 6'h00;
  localparam logic [5:0] RJ_NOT_READY = 6'h01; // 1
  localparam logic [5:0] RJ_NO_ACK    = 6'h03; // 3
  localparam logic [5:0] RJ_FILE_PROT = 6'h05; // 5
  localparam logic [5:0] RJ_ILLEGAL   = 6'h07; // 7
  localparam logic [5:0] RJ_AT_LOAD   = 6'h13; // 23
  localparam logic [5:0] RJ_LONG_GAP  = 6'h15; // 25
  localparam logic [5:0] RJ_SPEED_REQ = 6'h16; // 26
  localparam logic [5:0] RJ_DENSITY   = 6'h18; // 30
  localparam logic [5:0] RJ_BOT_WRITE = 6'h19; // 31
  localparam logic [5:0] RJ_NO_MOTION = 6'h1A; // 32
  localparam logic [5:0] RJ_GAP_DATA  = 6'h1B; // 33
  localparam logic [5:0] RJ_NO_DATA   = 6'h1F; // 37

  // Bit n set: code n also raises operation_incomplete
  localparam logic [31:0] OPERATION_INCOMPLETE_MASK   = 32'hED33_934C;
  // Bit n set: code n is reserved (or zero) and never shown
  localparam logic [31:0] RESERVED_MASK = 32'h1084_6C11;

  // ==========================================================
  // Gap and timing limits
  localparam logic [4:0] GAP_LIMIT_PHASE_FT = 5'h19; // 25 feet
  localparam logic [4:0] GAP_LIMIT_GROUP_FT = 5'h0F; // 15 feet
  localparam int ACK_TIMEOUT_MS = 75;
  localparam int CLK_PERIOD_NS  = 5;
  localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

  // ==========================================================
  // Carrier types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } tues_state_e;

  typedef struct packed {
    logic write_type;
    logic backward;
    logic rewind;
    logic read_space;
    logic bot_write;
    logic speed_change;
    logic illegal;
    logic keep_status;
  } tues_cmd_s;

  typedef struct packed {
    logic tape_loaded;
    logic rewinding;
    logic machine_check;
    logic at_load_point;
    logic file_protect;
    logic at_end;
    logic write_mode;
    logic high_density;
  } tues_drv_s;

  typedef struct packed {
    logic end_mark_err;
    logic speed_out;
    logic corr_phase_read;
    logic corr_group_read;
    logic group_write_trk;
    logic gap_foot;
    logic gap_end;
    logic motion;
    logic density_miss;
    logic no_motion;
    logic rb_gap_data;
    logic rb_no_data;
  } tues_ev_s;

  typedef struct packed {
    logic [4:0] early;
    logic       unused;
    logic       eor_fault;
    logic       speed_fault;
    logic       diag;
  } tues_byte1_s;

  typedef struct packed {
    logic       speed_pulse;
    logic [1:0] aid;
    logic [5:0] code;
  } tues_byte2_s;

  typedef struct packed {
    logic write_st;
    logic eot;
    logic load_pt;
    logic unused;
    logic fprot;
    logic reverse;
    logic high_dens;
    logic ready;
    logic online;
  } tues_byte3_s;

endpackage

// *** hw/tues_top.sv ***
// Ending-status, reject-code and error-mux logic of the tape unit
`timescale 1ns/1ps
`default_nettype none

module tues_top #(
  parameter int ACK_TIMEOUT_CYCLES = tues_pkg::ACK_TIMEOUT_CYC,
  parameter int ACK_CNT_W          = 24
) (
  input  wire logic                CLK_SYS,
  input  wire logic                RST_N,
  input  wire logic                CLK_EN,
  input  wire logic                CMD_START,
  input  wire tues_pkg::tues_cmd_s CMD,
  input  wire logic                CMD_DONE,
  input  wire tues_pkg::tues_drv_s DRIVE,
  input  wire tues_pkg::tues_ev_s  EV,
  input  wire logic                EXT_REJ_VALID,
  input  wire logic [5:0]          EXT_REJ_CODE,
  input  wire logic                DIAG_MODE,
  input  wire logic [1:0]          DIAG_AID,
  input  wire logic                SPEED_PULSE,
  input  wire logic [8:0]          DEAD_TRACK,
  input  wire logic [4:0]          EARLY_ERRORS,
  input  wire logic                XFER_REQ,
  input  wire logic                XFER_ACK,
  input  wire logic [8:0]          BUS_DATA,
  input  wire logic                ONLINE_KEY,
  input  wire logic                RESET_KEY,
  input  wire logic [2:0]          MUX_SEL,
  output logic [8:0]               ERROR_MUX_BUS,
  output logic                     BUSY,
  output logic                     REJECT,
  output logic                     OP_INCOMPLETE,
  output logic                     DATA_FAULT,
  output logic                     FIXED_ERROR_LINE,
  output logic                     BUS_PARITY_FAULT,
  output logic                     ONLINE_FLAG,
  output logic                     READY_FLAG,
  output logic                     WRITE_STATUS,
  output logic                     END_OF_TAPE,
  output logic                     LOAD_POINT,
  output logic                     FILE_PROTECT,
  output logic                     HIGH_DENSITY
);
  import tues_pkg::*;

  if (ACK_TIMEOUT_CYCLES < 2 || ACK_TIMEOUT_CYCLES >= (2 ** ACK_CNT_W))
  begin : g_chk
    $error("ACK_TIMEOUT_CYCLES does not fit the ack counter");
  end

  // ==========================================================
  // Helpers
  function automatic logic [5:0] shown_code(input logic [5:0] c);
    // Reserved codes would confuse host software; show none instead
    shown_code = RESERVED_MASK[c[4:0]] || c[5] ? RJ_NONE : c;
  endfunction

  function automatic logic sets_operation_incomplete(input logic [5:0] c);
    sets_operation_incomplete = !c[5] && OPERATION_INCOMPLETE_MASK[c[4:0]];
  endfunction

  // ==========================================================
  // State
  tues_state_e state_q;
  tues_cmd_s   cmd_q;
  tues_drv_s   drv_q;
  logic        reject_q;
  logic [5:0]  code_q;
  logic        operation_incomplete_q;
  logic        eor_q;
  logic        speed_q;
  logic        data_fault_q;
  logic        fixed_q;
  logic        parity_q;
  logic        reverse_q;
  logic        online_q;
  logic        ready_q;
  logic        diag_q;
  logic        speed_pend_q;
  logic        ack_wait_q;
  logic        ack_seen_q;
  logic [ACK_CNT_W-1:0] ack_cnt_q;
  logic [4:0]  gap_cnt_q;
  logic [8:0]  mux_q;

  logic        running;
  logic        start_ok;
  logic        clr;
  logic [5:0]  imm_code;
  logic [5:0]  run_code;
  logic        rej_fire;
  logic [5:0]  rej_code;
  logic        ack_timeout;
  logic        long_gap;
  logic        xfer;
  logic        par_err;

  assign running  = (state_q == ST_RUN);
  assign start_ok = CMD_START && online_q && (state_q == ST_IDLE);
  assign clr      = start_ok && !CMD.keep_status;
  assign xfer     = running && (cmd_q.write_type || cmd_q.read_space);
  assign par_err  = running && XFER_REQ && XFER_ACK && !(^BUS_DATA);

  // ==========================================================
  // Start-time reject decision
  always_comb
  begin
    imm_code = RJ_NONE;
    if (!ready_q)
      imm_code = RJ_NOT_READY;
    else if (CMD.illegal)
      imm_code = RJ_ILLEGAL;
    else if (CMD.backward && !CMD.rewind && drv_q.at_load_point)
      imm_code = RJ_AT_LOAD;
    else if (CMD.bot_write && drv_q.tape_loaded && !drv_q.at_load_point)
      imm_code = RJ_BOT_WRITE;
    else if (CMD.write_type && drv_q.file_protect)
      imm_code = RJ_FILE_PROT;
    else if (CMD.speed_change && speed_pend_q)
      imm_code = RJ_SPEED_REQ;
  end

  // ==========================================================
  // Run-time reject decision
  always_comb
  begin
    run_code = RJ_NONE;
    if (ack_timeout)
      run_code = RJ_NO_ACK;
    else if (long_gap)
      run_code = RJ_LONG_GAP;
    else if (EV.density_miss)
      run_code = RJ_DENSITY;
    else if (EV.no_motion)
      run_code = RJ_NO_MOTION;
    else if (cmd_q.write_type && EV.rb_gap_data)
      run_code = RJ_GAP_DATA;
    else if (cmd_q.write_type && EV.rb_no_data)
      run_code = RJ_NO_DATA;
    else if (EXT_REJ_VALID)
      run_code = EXT_REJ_CODE;
  end

  assign rej_code = start_ok ? imm_code : run_code;
  assign rej_fire = (start_ok || running) && (rej_code != RJ_NONE);

  // ==========================================================
  // Command sequencing; busy covers the whole command
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q <= ST_IDLE;
      cmd_q   <= '0;
    end
    else if (CLK_EN)
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (start_ok)
          begin
            cmd_q <= CMD;
            if (imm_code == RJ_NONE)
              state_q <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          // Parity fault never ends the transfer
          if (CMD_DONE || rej_fire)
            state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Reject code and incomplete flag
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      reject_q <= 1'b0;
      code_q   <= RJ_NONE;
      operation_incomplete_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (rej_fire)
      begin
        reject_q <= 1'b1;
        code_q   <= shown_code(rej_code);
        operation_incomplete_q <= sets_operation_incomplete(rej_code);
      end
      else if (clr)
      begin
        reject_q <= 1'b0;
        code_q   <= RJ_NONE;
        operation_incomplete_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Error flags; a set in the clearing cycle wins
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      eor_q        <= 1'b0;
      speed_q      <= 1'b0;
      fixed_q      <= 1'b0;
      parity_q     <= 1'b0;
      data_fault_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      eor_q    <= (xfer && EV.end_mark_err) || (eor_q && !clr);
      speed_q  <= (running && cmd_q.write_type && EV.speed_out)
                  || (speed_q && !clr);
      fixed_q  <= (running && (EV.corr_phase_read || EV.corr_group_read
                  || EV.group_write_trk)) || (fixed_q && !clr);
      parity_q <= par_err || (parity_q && !clr);
      data_fault_q <= (xfer && EV.end_mark_err)
                      || (running && cmd_q.write_type && EV.speed_out)
                      || par_err || (data_fault_q && !clr);
    end
  end

  // ==========================================================
  // First transfer acknowledge timer
  assign ack_timeout = ack_wait_q && !XFER_ACK
                       && (ack_cnt_q == ACK_CNT_W'(ACK_TIMEOUT_CYCLES - 1));

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ack_wait_q <= 1'b0;
      ack_seen_q <= 1'b0;
      ack_cnt_q  <= '0;
    end
    else if (CLK_EN)
    begin
      if (!running || XFER_ACK || ack_seen_q)
      begin
        ack_wait_q <= 1'b0;
        ack_cnt_q  <= '0;
        ack_seen_q <= running && (XFER_ACK || ack_seen_q);
      end
      else if (cmd_q.write_type && (XFER_REQ || ack_wait_q))
      begin
        ack_wait_q <= 1'b1;
        ack_cnt_q  <= ack_cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // Gap length in feet on read and space commands
  assign long_gap = cmd_q.read_space && (gap_cnt_q >
                    (drv_q.high_density ? GAP_LIMIT_GROUP_FT : GAP_LIMIT_PHASE_FT));

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      gap_cnt_q <= '0;
    else if (CLK_EN)
    begin
      if (!running || EV.gap_end)
        gap_cnt_q <= '0;
      else if (EV.gap_foot && gap_cnt_q != '1)
        gap_cnt_q <= gap_cnt_q + 1'b1;
    end
  end

  // ==========================================================
  // Speed-change bookkeeping and motion direction
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      speed_pend_q <= 1'b0;
      reverse_q    <= 1'b0;
    end
    else if (CLK_EN)
    begin
      speed_pend_q <= (start_ok && CMD.speed_change && imm_code == RJ_NONE)
                      || (speed_pend_q && !EV.motion);
      if (start_ok && imm_code == RJ_NONE && (CMD.write_type
          || CMD.read_space || CMD.backward || CMD.rewind))
        reverse_q <= CMD.backward || CMD.rewind;
    end
  end

  // ==========================================================
  // Online, ready, diagnostic and mirrored drive status
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      online_q <= 1'b0;
      ready_q  <= 1'b0;
      diag_q   <= 1'b0;
      drv_q    <= '0;
    end
    else if (CLK_EN)
    begin
      online_q <= ONLINE_KEY || (online_q && !RESET_KEY);
      ready_q  <= DRIVE.tape_loaded && !DRIVE.rewinding && !DRIVE.machine_check;
      diag_q   <= DIAG_MODE;
      drv_q    <= DRIVE;
    end
  end

  // ==========================================================
  // Error multiplex bus
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      mux_q <= '0;
    else if (CLK_EN)
    begin
      unique case (MUX_SEL)
        SEL_DEAD_TRACK:
          mux_q <= DEAD_TRACK;
        SEL_RW_ERRORS:
          mux_q <= tues_byte1_s'{EARLY_ERRORS, 1'b0, eor_q, speed_q, diag_q};
        SEL_DIAG_AID:
          mux_q <= tues_byte2_s'{SPEED_PULSE, diag_q ? DIAG_AID : 2'b00, code_q};
        SEL_STATUS:
          mux_q <= tues_byte3_s'{drv_q.write_mode, drv_q.at_end,
                   drv_q.at_load_point, 1'b0, drv_q.file_protect, reverse_q,
                   drv_q.high_density, ready_q, online_q};
        default:
          mux_q <= '0;
      endcase
    end
  end

  assign ERROR_MUX_BUS    = mux_q;
  assign BUSY             = running;
  assign REJECT           = reject_q;
  assign OP_INCOMPLETE    = operation_incomplete_q;
  assign DATA_FAULT       = data_fault_q;
  assign FIXED_ERROR_LINE = fixed_q;
  assign BUS_PARITY_FAULT = parity_q;
  assign ONLINE_FLAG      = online_q;
  assign READY_FLAG       = ready_q;
  assign WRITE_STATUS     = drv_q.write_mode;
  assign END_OF_TAPE      = drv_q.at_end;
  assign LOAD_POINT       = drv_q.at_load_point;
  assign FILE_PROTECT     = drv_q.file_protect;
  assign HIGH_DENSITY     = drv_q.high_density;

  // ==========================================================
  // Checks
  property p_not_ready;
    @(posedge CLK_SYS) disable iff (!RST_N)
    CLK_EN && start_ok && !ready_q |=> REJECT && code_q == RJ_NOT_READY && !OP_INCOMPLETE;
  endproperty
  a_not_ready: assert property (p_not_ready)
    else $error("not-ready start did not reject with code 1");

  property p_offline;
    @(posedge CLK_SYS) disable iff (!RST_N)
    CLK_EN && CMD_START && !online_q && !running |=> !BUSY && $stable(code_q);
  endproperty
  a_offline: assert property (p_offline)
    else $error("command accepted while offline");

  property p_ready;
    @(posedge CLK_SYS) disable iff (!RST_N)
    CLK_EN && (!DRIVE.tape_loaded || DRIVE.rewinding) |=> !READY_FLAG;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready shown without loaded idle tape");

  property p_parity;
    @(posedge CLK_SYS) disable iff (!RST_N)
    CLK_EN && par_err |=> BUS_PARITY_FAULT && DATA_FAULT;
  endproperty
  a_parity: assert property (p_parity)
    else $error("even parity not flagged");

  property p_no_halt;
    @(posedge CLK_SYS) disable iff (!RST_N)
    CLK_EN && running && par_err && !CMD_DONE && run_code == RJ_NONE |=> BUSY;
  endproperty
  a_no_halt: assert property (p_no_halt)
    else $error("parity fault halted transfer");

  property p_operation_incomplete;
    @(posedge CLK_SYS) disable iff (!RST_N)
    CLK_EN && REJECT && !$past(rej_fire) |-> OP_INCOMPLETE == sets_operation_incomplete(code_q);
  endproperty
  a_operation_incomplete: assert property (p_operation_incomplete)
    else $error("incomplete flag disagrees with reject code");

  property p_reserved;
    @(posedge CLK_SYS) disable iff (!RST_N)
    1'b1 |-> !RESERVED_MASK[code_q[4:0]] || code_q == RJ_NONE;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved reject code shown");

  property p_timeout;
    @(posedge CLK_SYS) disable iff (!RST_N)
    CLK_EN && ack_timeout |=> REJECT && code_q == RJ_NO_ACK && OP_INCOMPLETE && !BUSY;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("ack timeout not rejected with code 3");

  property p_mux_status;
    @(posedge CLK_SYS) disable iff (!RST_N)
    CLK_EN && MUX_SEL == SEL_STATUS ##1 CLK_EN |->
      ERROR_MUX_BUS[0] == $past(online_q) && ERROR_MUX_BUS[1] == $past(ready_q);
  endproperty
  a_mux_status: assert property (p_mux_status)
    else $error("status byte disagrees with status lines");

endmodule

`default_nettype wire

// *** tb/tues_host.sv ***
// Host controller model answering transfer requests from the tape unit
`timescale 1ns/1ps
`default_nettype none

module tues_host (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       req,
  input  wire logic [7:0] ack_delay,
  input  wire logic       bad_par,
  output logic            ack,
  output logic [8:0]      data
);
  logic [7:0] wait_q;

  // ==========================================================
  // Handshake
  // Prompt, late or absent acknowledge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q <= 8'h00;
      ack    <= 1'b0;
    end
    else if (!req)
    begin
      wait_q <= 8'h00;
      ack    <= 1'b0;
    end
    else
    begin
      wait_q <= wait_q + 8'h01;
      // Zero delay stands for a host that never answers
      ack    <= (ack_delay != 8'h00) && (wait_q >= ack_delay - 8'h01);
    end
  end

  // ==========================================================
  // Data bus
  // Odd parity while req is high unless told otherwise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      data <= 9'h000;
    else if (req)
      data <= bad_par ? 9'h003 : 9'h007;
    else
      data <= ~data;
  end
endmodule

`default_nettype wire

// *** tb/tues_top_bench.sv ***
// Self-checking bench for the tape unit ending-status block
`timescale 1ns/1ps
`default_nettype none

module tues_top_bench;
  import tues_pkg::*;

  logic       clk_sys = 1'b0;
  logic       rst_n   = 1'b0;
  logic       start   = 1'b0;
  tues_cmd_s  cmd     = '0;
  logic       done    = 1'b0;
  tues_drv_s  drive   = '0;
  tues_ev_s   ev      = '0;
  logic       diag    = 1'b0;
  logic       dprev   = 1'b0;
  logic [1:0] aid     = 2'h0;
  logic       sp      = 1'b0;
  logic       sp_q    = 1'b0;
  logic [8:0] dead    = 9'h000;
  logic       req     = 1'b0;
  logic       on_key  = 1'b0;
  logic       off_key = 1'b0;
  logic [2:0] sel     = 3'h2;
  logic [7:0] dly     = 8'h00;
  logic       bad     = 1'b0;
  logic       xv      = 1'b0;
  logic [5:0] xc      = 6'h00;
  logic [4:0] early   = 5'h00;
  wire  [4:0] mir;
  logic [8:0] bdata, mux, exp;
  logic       ack, busy, rej, inc, dflt, fixed, bpar, onl, rdy;
  int         err_count    = 0;
  int         total_checks = 0;
  int         seed         = 32472;
  int         rcode[4]     = '{24, 26, 27, 31};
  // Octal starred codes, in decimal
  int         starred[$]   = '{2, 3, 6, 8, 9, 12, 15, 16, 17, 20, 21, 24, 26, 27, 29, 30, 31};

  always #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    sp_q <= sp;
    sp   <= 1'($random(seed));
  end

  tues_top #(.ACK_TIMEOUT_CYCLES(20)) i_tues_top (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .CLK_EN(1'b1), .CMD_START(start), .CMD(cmd),
    .CMD_DONE(done), .DRIVE(drive), .EV(ev), .EXT_REJ_VALID(xv), .EXT_REJ_CODE(xc),
    .DIAG_MODE(diag), .DIAG_AID(aid), .SPEED_PULSE(sp), .DEAD_TRACK(dead),
    .EARLY_ERRORS(early), .XFER_REQ(req), .XFER_ACK(ack), .BUS_DATA(bdata),
    .ONLINE_KEY(on_key), .RESET_KEY(off_key), .MUX_SEL(sel), .ERROR_MUX_BUS(mux),
    .BUSY(busy), .REJECT(rej), .OP_INCOMPLETE(inc), .DATA_FAULT(dflt),
    .FIXED_ERROR_LINE(fixed), .BUS_PARITY_FAULT(bpar), .ONLINE_FLAG(onl), .READY_FLAG(rdy),
    .WRITE_STATUS(mir[1]), .END_OF_TAPE(mir[2]), .LOAD_POINT(mir[4]),
    .FILE_PROTECT(mir[3]), .HIGH_DENSITY(mir[0]));

  tues_host i_tues_host (.clk(clk_sys), .rst_n(rst_n), .req(req), .ack_delay(dly),
    .bad_par(bad), .ack(ack), .data(bdata));

  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] want);
    total_checks++;
    if (seen !== want)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic issue(input tues_cmd_s c);
    @(posedge clk_sys);
    cmd   <= c;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    tick(2);
  endtask

  task automatic setdrv(input tues_drv_s d);
    @(posedge clk_sys);
    drive <= d;
    tick(2);
    chk("ready", 9'(rdy), 9'(d.tape_loaded & !d.rewinding & !d.machine_check));
    chk("mirror", 9'(mir), 9'(d[4:0]));
  endtask

  task automatic pulse(input tues_ev_s e);
    @(posedge clk_sys);
    ev <= e;
    @(posedge clk_sys);
    ev <= '0;
    tick(1);
  endtask

  // Mux must sit on selector 2 with diagnostic mode off
  task automatic want_rej(input int code);
    chk("reject", {busy, rej}, 9'h001);
    chk("code", 9'(mux[7:0]), 9'(code));
    chk("incomplete", 9'(inc), 9'(code inside {starred}));
  endtask

  task automatic done_cmd;
    chk("busy", 9'(busy), 9'h001);
    @(posedge clk_sys);
    done <= 1'b1;
    @(posedge clk_sys);
    done <= 1'b0;
    tick(1);
    chk("idle", {busy, rej}, 9'h000);
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Whole run is a few hundred cycles
  initial
  begin
    #20000;
    err_count++;
    tally_and_finish;
  end

  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    on_key <= 1'b1;
    @(posedge clk_sys);
    on_key <= 1'b0;
    tick(1);
    chk("online", 9'(onl), 9'h001);
    setdrv(8'hC0);
    setdrv(8'h00);
    issue(8'h80);
    want_rej(1);
    setdrv(8'h90);
    issue(8'h02);
    want_rej(7);
    issue(8'h40);
    want_rej(19);
    setdrv(8'h80);
    issue(8'h08);
    want_rej(25);
    setdrv(8'h88);
    issue(8'h80);
    want_rej(5);
    setdrv(8'h87);
    setdrv(8'h80);
    issue(8'h04);
    done_cmd;
    issue(8'h04);
    want_rej(22);
    $display("Test start rejects done");
    for (int i = 0; i < 4; i++)
    begin
      issue(i < 2 ? 8'h10 : 8'h80);
      pulse(12'h008 >> i);
      tick(1);
      want_rej(rcode[i]);
    end
    // Gap of exactly the limit must not reject; one more foot must
    issue(8'h10);
    @(posedge clk_sys);
    ev <= 12'h040;
    repeat (25) @(posedge clk_sys);
    ev <= '0;
    tick(1);
    chk("gap", 9'(busy), 9'h001);
    pulse(12'h040);
    tick(1);
    want_rej(21);
    // Reserved code from another source is hidden, starred one shown
    for (int i = 0; i < 2; i++)
    begin
      issue(8'h10);
      @(posedge clk_sys);
      xv <= 1'b1;
      xc <= (i == 0) ? 6'h04 : 6'h08;
      @(posedge clk_sys);
      xv <= 1'b0;
      tick(2);
      want_rej(i * 8);
    end
    issue(8'h80);
    @(posedge clk_sys);
    req <= 1'b1;
    for (int n = 0; n < 40 && rej !== 1'b1; n++)
      tick(1);
    @(posedge clk_sys);
    req <= 1'b0;
    dly <= 8'h02;
    bad <= 1'b1;
    tick(2);
    want_rej(3);
    $display("Test run rejects done");
    issue(8'h40);
    done_cmd;
    @(posedge clk_sys);
    sel <= 3'h3;
    tick(2);
    chk("status", mux, 9'h00B);
    issue(8'h10);
    pulse(12'h200);
    chk("fixed", 9'(fixed), 9'h001);
    done_cmd;
    chk("status", mux, 9'h003);
    issue(8'h80);
    @(posedge clk_sys);
    req <= 1'b1;
    tick(30);
    chk("parity", {bpar, dflt, busy}, 9'h007);
    pulse(12'hC00);
    @(posedge clk_sys);
    sel <= 3'h1;
    req <= 1'b0;
    tick(2);
    chk("errors", mux, 9'h006);
    done_cmd;
    $display("Test transfer done");
    // Diagnostic bits follow the mode as latched one cycle earlier
    for (int i = 0; i < 24; i++)
    begin
      @(posedge clk_sys);
      dprev = diag;
      sel   <= 3'($random(seed));
      dead  <= 9'($random(seed));
      diag  <= 1'($random(seed));
      aid   <= 2'($random(seed));
      early <= 5'($random(seed));
      tick(1);
      case (sel)
        3'h0: exp = dead;
        3'h1: exp = {early, 3'h3, dprev};
        3'h2: exp = {sp_q, dprev ? aid : 2'h0, 6'h00};
        3'h3: exp = 9'h003;
        default: exp = 9'h000;
      endcase
      chk("mux", mux, exp);
    end
    $display("Test mux done");
    @(posedge clk_sys);
    off_key <= 1'b1;
    @(posedge clk_sys);
    off_key <= 1'b0;
    tick(1);
    chk("offline", 9'(onl), 9'h000);
    issue(8'h02);
    chk("ignored", {busy, rej}, 9'h000);
    $display("Test online done");
    tally_and_finish;
  end
endmodule

`default_nettype wire
